// *** verilog/dcc_channel.sv ***
// debug communication channel with its test access port gating
// How it works
// (RULE1) a cpu write to the channel register queues the byte for the debugger unless the fifo is full
// (RULE2) every cpu write to the channel register sets the dirty flag
// (RULE3) cpu read returns seven low data bits, dirty flag in the top bit
// (RULE4) the debugger clears the dirty flag once it has read the byte
// (RULE5) shared address reaches the channel only with fuse and debugger enable
// (RULE6) otherwise accesses at the shared address go to the ordinary i/o location
// (RULE7) test port runs only with its fuse programmed and disable bit clear
// (RULE8) the debugger needs only tck, tms, tdi and tdo besides power
// (RULE9) reset clears the dirty flag and the channel byte
`timescale 1ns/100ps
module dcc_channel (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire dcc_pkg::dcc_bus_req_s bus_req,
  output logic [dcc_pkg::DATA_W-1:0] rdata,
  output logic                       io_wr,
  output logic                       io_rd,
  output logic [dcc_pkg::DATA_W-1:0] io_wdata,
  input  wire logic [dcc_pkg::DATA_W-1:0] io_rdata,
  input  wire dcc_pkg::dcc_fuses_s   fuses,
  input  wire dcc_pkg::dcc_pins_s    pins,
  output logic                       tdo,
  output logic                       tdo_oe,
  output logic                       chan_wr_ready,
  output logic                       tap_enabled
);
  import dcc_pkg::*;

  typedef enum logic [3:0] {
    TAP_RESET    = 4'b0000,
    TAP_IDLE     = 4'b0001,
    TAP_SEL_DR   = 4'b0010,
    TAP_CAP_DR   = 4'b0011,
    TAP_SHIFT_DR = 4'b0100,
    TAP_EXIT1_DR = 4'b0101,
    TAP_PAUSE_DR = 4'b0110,
    TAP_EXIT2_DR = 4'b0111,
    TAP_UPD_DR   = 4'b1000,
    TAP_SEL_IR   = 4'b1001,
    TAP_CAP_IR   = 4'b1010,
    TAP_SHIFT_IR = 4'b1011,
    TAP_EXIT1_IR = 4'b1100,
    TAP_PAUSE_IR = 4'b1101,
    TAP_EXIT2_IR = 4'b1110,
    TAP_UPD_IR   = 4'b1111
  } dcc_tap_e;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  logic [1:0] rst_pipe;
  logic       rst_sync_b;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe[1];

  dcc_pins_s  pins_s;
  dcc_fuses_s fuses_s;

  dcc_sync #(
    .WIDTH ($bits(dcc_pins_s) + $bits(dcc_fuses_s))
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_sync_b),
    .async_in ({pins, fuses}),
    .sync_out ({pins_s, fuses_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode and routing of the shared location
  logic             access_en;
  logic             disable_bit;
  logic             route_dbg;
  logic             shared_hit;
  logic             chan_wr_hit;
  logic             chan_rd_hit;
  logic             csr_wr_hit;
  logic             csr_rd_hit;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] b);
    return a == b;
  endfunction

  assign route_dbg = fuses_s.debug_enable_fuse && access_en; // [RULE5]
  assign shared_hit = addr_is(bus_req.addr, CHAN_OFFSET);
  assign chan_wr_hit = bus_req.wr && shared_hit && route_dbg; // [RULE5]
  assign chan_rd_hit = bus_req.rd && shared_hit && route_dbg;
  assign csr_wr_hit = bus_req.wr && addr_is(bus_req.addr, CSR_OFFSET);
  assign csr_rd_hit = bus_req.rd && addr_is(bus_req.addr, CSR_OFFSET);
  // the ordinary location sees the access whenever the channel is not routed in
  assign io_wr = bus_req.wr && shared_hit && !route_dbg; // [RULE6]
  assign io_rd = bus_req.rd && shared_hit && !route_dbg; // [RULE6]
  assign io_wdata = bus_req.wdata;
  assign tap_enabled = fuses_s.test_port_enable_fuse && !disable_bit; // [RULE7]

  ////////////////////////////////////////////////////////////////////////////
  // channel byte, dirty flag and fifo towards the debugger
  logic [DATA_W-1:0] chan_byte, next_chan_byte;
  logic              dirty, next_dirty;
  logic              fifo_valid;
  logic              fifo_pop;
  logic [DATA_W-1:0] fifo_head;
  logic              dbg_read_done;

  // a full fifo drops the queued copy; the byte and flag still follow the write
  dcc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_sync_b),
    .in_valid  (chan_wr_hit),
    .in_ready  (chan_wr_ready),
    .in_data   (bus_req.wdata),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_head)
  );

  always_comb begin
    next_chan_byte = chan_byte;
    next_dirty = dirty;
    if (dbg_read_done) begin
      next_dirty = 1'b0; // [RULE4]
    end
    // a cpu write in the clearing cycle wins over the debugger
    if (chan_wr_hit) begin
      next_chan_byte = bus_req.wdata; // [RULE1]
      next_dirty = 1'b1; // [RULE2]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      chan_byte <= CHAN_RESET; // [RULE9]
      dirty <= 1'b0; // [RULE9]
    end else begin
      chan_byte <= next_chan_byte;
      dirty <= next_dirty;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register and read data
  logic [DATA_W-1:0] next_rdata;
  logic              next_disable_bit;

  always_comb begin
    next_disable_bit = disable_bit;
    next_rdata = RDATA_RESET;
    if (csr_wr_hit) begin
      next_disable_bit = bus_req.wdata[CSR_DISABLE_BIT];
    end
    if (chan_rd_hit) begin
      next_rdata = {dirty, chan_byte[CHAN_DIRTY_BIT-1:0]}; // [RULE3]
    end else if (io_rd) begin
      next_rdata = io_rdata; // [RULE6]
    end else if (csr_rd_hit) begin
      next_rdata[CSR_DISABLE_BIT] = disable_bit;
      next_rdata[CSR_TAP_ON_BIT] = tap_enabled;
      next_rdata[CSR_FULL_BIT] = !chan_wr_ready;
      next_rdata[CSR_ROUTE_BIT] = route_dbg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      disable_bit <= CSR_DISABLE_RESET;
      rdata <= RDATA_RESET;
    end else begin
      disable_bit <= next_disable_bit;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // test access port, stepped on sampled tck edges
  dcc_tap_e          tap_state, next_tap_state;
  logic              tck_q, next_tck_q;
  logic              tck_rise, tck_fall;
  logic [IR_W-1:0]   ir_shift, next_ir_shift;
  logic [IR_W-1:0]   ir, next_ir;
  logic [DR_W-1:0]   dr, next_dr;
  logic              next_access_en;
  logic              next_tdo, next_tdo_oe;
  logic              one_bit_dr;

  // only the synchronised tck is looked at; 8 sys_clk per tck period in use
  assign tck_rise = pins_s.tck && !tck_q; // [RULE8]
  assign tck_fall = !pins_s.tck && tck_q;
  assign one_bit_dr = (ir != INS_CHAN_READ);
  assign dbg_read_done = tck_rise && (tap_state == TAP_UPD_DR)
                         && (ir == INS_CHAN_READ);
  assign fifo_pop = dbg_read_done && fifo_valid;

  always_comb begin
    next_tap_state = tap_state;
    unique case (tap_state)
      TAP_RESET:    next_tap_state = pins_s.tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:     next_tap_state = pins_s.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:   next_tap_state = pins_s.tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR:   next_tap_state = pins_s.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: next_tap_state = pins_s.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: next_tap_state = pins_s.tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: next_tap_state = pins_s.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: next_tap_state = pins_s.tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR:   next_tap_state = pins_s.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:   next_tap_state = pins_s.tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR:   next_tap_state = pins_s.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: next_tap_state = pins_s.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: next_tap_state = pins_s.tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: next_tap_state = pins_s.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: next_tap_state = pins_s.tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR:   next_tap_state = pins_s.tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  always_comb begin
    next_tck_q = pins_s.tck;
    next_ir_shift = ir_shift;
    next_ir = ir;
    next_dr = dr;
    next_access_en = access_en;
    next_tdo = tdo;
    next_tdo_oe = tdo_oe;
    if (!tap_enabled) begin
      next_ir = INS_BYPASS; // [RULE7]
      next_tdo_oe = 1'b0; // [RULE7]
      // a port held in test-logic-reset cannot keep the debugger's grant alive
      next_access_en = 1'b0; // [RULE5]
    end else if (tck_rise) begin
      unique case (tap_state)
        TAP_RESET: begin
          next_ir = INS_BYPASS;
          next_access_en = 1'b0;
        end
        TAP_CAP_IR:   next_ir_shift = IR_CAPTURE;
        TAP_SHIFT_IR: next_ir_shift = {pins_s.tdi, ir_shift[IR_W-1:1]};
        TAP_UPD_IR:   next_ir = ir_shift;
        TAP_CAP_DR: begin
          if (ir == INS_CHAN_READ) begin
            // the queued byte when present, else the last written one
            next_dr = {dirty, fifo_valid ? fifo_head : chan_byte};
          end else if (ir == INS_CHAN_CTRL) begin
            next_dr = {{(DR_W-1){1'b0}}, access_en};
          end else begin
            next_dr = '0;
          end
        end
        TAP_SHIFT_DR: begin
          if (one_bit_dr) begin
            next_dr[0] = pins_s.tdi;
          end else begin
            next_dr = {pins_s.tdi, dr[DR_W-1:1]};
          end
        end
        TAP_UPD_DR: begin
          if (ir == INS_CHAN_CTRL) begin
            next_access_en = dr[0]; // [RULE5]
          end
        end
        default: begin
        end
      endcase
    end else if (tck_fall) begin
      // tdo moves on the falling edge so the debugger samples a settled bit
      next_tdo_oe = (tap_state == TAP_SHIFT_DR) || (tap_state == TAP_SHIFT_IR);
      next_tdo = (tap_state == TAP_SHIFT_IR) ? ir_shift[0] : dr[0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tap_state <= TAP_RESET;
      tck_q <= 1'b0;
      ir_shift <= IR_CAPTURE;
      ir <= INS_BYPASS;
      dr <= '0;
      access_en <= 1'b0;
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      // a disabled port is held in its reset state
      tap_state <= !tap_enabled ? TAP_RESET
                 : (tck_rise ? next_tap_state : tap_state); // [RULE7]
      tck_q <= next_tck_q;
      ir_shift <= next_ir_shift;
      ir <= next_ir;
      dr <= next_dr;
      access_en <= next_access_en;
      tdo <= next_tdo;
      tdo_oe <= next_tdo_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_sync_b);

  a_write_stores_byte: assert property ( // [RULE1]
    chan_wr_hit |=> chan_byte == $past(bus_req.wdata))
    else $error("channel byte not stored on write");

  a_write_sets_dirty: assert property ( // [RULE2]
    chan_wr_hit |=> dirty)
    else $error("dirty flag not set by write");

  a_read_format: assert property ( // [RULE3]
    chan_rd_hit |=> rdata == {$past(dirty), $past(chan_byte[6:0])})
    else $error("channel read data malformed");

  a_debugger_clears: assert property ( // [RULE4]
    (dbg_read_done && !chan_wr_hit) |=> !dirty)
    else $error("dirty flag not cleared by debugger read");

  a_route_gated: assert property ( // [RULE5]
    (bus_req.wr && shared_hit && !(fuses_s.debug_enable_fuse && access_en))
    |=> chan_byte == $past(chan_byte))
    else $error("channel written while not routed");

  a_io_fallback: assert property ( // [RULE6]
    (bus_req.rd && shared_hit && !route_dbg) |-> io_rd ##1 rdata == $past(io_rdata))
    else $error("shared read did not reach the i/o location");

  a_tap_gated: assert property ( // [RULE7]
    !tap_enabled |=> tap_state == TAP_RESET && !tdo_oe)
    else $error("test port active while disabled");

  a_grant_dropped: assert property ( // [RULE5]
    !tap_enabled |=> !access_en)
    else $error("debugger grant kept while port disabled");

  a_reset_clean: assert property ( // [RULE9]
    $rose(rst_sync_b) |-> !dirty && chan_byte == CHAN_RESET)
    else $error("channel not clean after reset");
endmodule // dcc_channel

// *** verilog/dcc_pkg.sv ***
// package for the debug communication channel: offsets, fields, codes and carriers
package dcc_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned SYNC_STAGES = 2;
  // i/o address shared between the channel register and an ordinary i/o location
  localparam logic [ADDR_W-1:0] CHAN_OFFSET = 6'h22;
  localparam logic [ADDR_W-1:0] CSR_OFFSET = 6'h34;
  localparam logic [DATA_W-1:0] CHAN_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;
  localparam int unsigned CHAN_DIRTY_BIT = 7;
  localparam int unsigned CSR_DISABLE_BIT = 7;
  localparam int unsigned CSR_TAP_ON_BIT = 0;
  localparam int unsigned CSR_FULL_BIT = 1;
  localparam int unsigned CSR_ROUTE_BIT = 2;
  localparam logic CSR_DISABLE_RESET = 1'b0;
  // instruction codes of the test port
  localparam int unsigned IR_W = 4;
  localparam int unsigned DR_W = 9;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] INS_CHAN_READ = 4'h1;
  localparam logic [IR_W-1:0] INS_CHAN_CTRL = 4'h2;
  localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } dcc_bus_req_s;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } dcc_pins_s;

  typedef struct packed {
    logic debug_enable_fuse;
    logic test_port_enable_fuse;
  } dcc_fuses_s;
endpackage

// *** verilog/dcc_sync.sv ***
// two flip-flop synchroniser for levels coming from outside the clock domain
`timescale 1ns/100ps
module dcc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import dcc_pkg::*;
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end
endmodule // dcc_sync

// *** verilog/dcc_fifo.sv ***
// small fifo with valid and ready on both sides
`timescale 1ns/100ps
module dcc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  import dcc_pkg::*;
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [PW:0]      count, next_count;
  logic             push, pop;

  assign in_ready = (count != FULL_COUNT);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr = (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end
endmodule // dcc_fifo

// *** dv/dcc_debugger_model.sv ***
// behavioural test-port debugger that drives the link pins of the channel
`timescale 1ns/100ps
module dcc_debugger_model (
  output var dcc_pkg::dcc_pins_s pins,
  input  wire logic              tdo
);
  import dcc_pkg::*;

  initial begin
    pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // one link clock: only tck, tms and tdi are driven and tdo observed
  // tck stands low between frames; tdo is taken late in the high phase because
  // the device only moves it a few system clocks after the falling edge
  task automatic step(input logic m, input logic d, output logic o);
    pins.tms = m;
    pins.tdi = d;
    #160;
    pins.tck = 1'b1;
    #160;
    o = tdo;
    pins.tck = 1'b0;
  endtask

  task automatic tap_reset();
    logic o;
    #7;
    repeat (5) step(1'b1, ~pins.tdi, o);
    step(1'b0, ~pins.tdi, o);
  endtask

  // ir selects the instruction path; bits go lsb first, idle tdi keeps toggling
  task automatic scan(input logic ir, input int n, input logic [8:0] din,
                      output logic [8:0] dout);
    logic o;
    #7;
    dout = '0;
    step(1'b1, ~pins.tdi, o);
    if (ir) step(1'b1, ~pins.tdi, o);
    step(1'b0, ~pins.tdi, o);
    step(1'b0, ~pins.tdi, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, ~pins.tdi, o); // into update; the next step's rising edge after a channel read clears the dirty flag
    step(1'b0, ~pins.tdi, o);
    pins.tdi = ~pins.tdi;
  endtask
endmodule // dcc_debugger_model

// *** dv/dcc_channel_test.sv ***
// self-checking bench for the debug communication channel
`timescale 1ns/100ps
module dcc_channel_test;
  import dcc_pkg::*;

  logic               sys_clk;
  logic               rst_b;
  dcc_bus_req_s       bus_req;
  logic [DATA_W-1:0]  rdata;
  logic [DATA_W-1:0]  io_wdata;
  logic [DATA_W-1:0]  io_rdata;
  logic               io_wr;
  logic               io_rd;
  logic               tdo;
  logic               tdo_oe;
  logic               chan_wr_ready;
  logic               tap_enabled;
  dcc_fuses_s         fuses;
  dcc_pins_s          pins;
  logic [8:0]         dr;
  int                 fails;
  int                 comparisons;

  always #20 sys_clk = ~sys_clk;

  dcc_channel u_dut (
    .sys_clk       (sys_clk),
    .rst_b         (rst_b),
    .bus_req       (bus_req),
    .rdata         (rdata),
    .io_wr         (io_wr),
    .io_rd         (io_rd),
    .io_wdata      (io_wdata),
    .io_rdata      (io_rdata),
    .fuses         (fuses),
    .pins          (pins),
    .tdo           (tdo),
    .tdo_oe        (tdo_oe),
    .chan_wr_ready (chan_wr_ready),
    .tap_enabled   (tap_enabled)
  );

  // a released tdo floats to its pull-up level, so the model never sees a stale bit
  dcc_debugger_model u_dbg (
    .pins (pins),
    .tdo  (tdo_oe ? tdo : 1'b1)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle write; to_io says whether the shared address should leave the block
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic to_io);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    #1;
    check1(io_wr, to_io);
    if (to_io) check8(io_wdata, d);
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [ADDR_W-1:0] a, input logic to_io, input logic [7:0] exp);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    #1;
    check1(io_rd, to_io);
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    check8(rdata, exp);
  endtask

  task automatic dbg_read(input logic [8:0] exp);
    u_dbg.scan(1'b0, DR_W, 9'h000, dr);
    check8(dr[7:0], exp[7:0]);
    check1(dr[8], exp[8]);
  endtask

  task automatic dbg_grant();
    u_dbg.tap_reset();
    u_dbg.scan(1'b1, IR_W, 9'(INS_CHAN_CTRL), dr);
    check8({4'h0, dr[3:0]}, {4'h0, IR_CAPTURE});
    u_dbg.scan(1'b0, 1, 9'h001, dr);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    $display("[FAIL] %0t run did not complete in time", $time);
    tally_and_finish();
  end

  initial begin
    sys_clk  = 1'b0;
    rst_b    = 1'b0;
    bus_req  = '0;
    io_rdata = 8'h3c;
    fuses    = '{debug_enable_fuse: 1'b1, test_port_enable_fuse: 1'b1};
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check1(tap_enabled, 1'b1);
    bus_rd(CSR_OFFSET, 1'b0, 8'h01);
    bus_wr(CHAN_OFFSET, 8'h77, 1'b1);
    bus_rd(CHAN_OFFSET, 1'b1, 8'h3c);
    bus_wr(6'h01, 8'hff, 1'b0);
    bus_rd(6'h01, 1'b0, 8'h00);
    dbg_grant();
    bus_rd(CSR_OFFSET, 1'b0, 8'h05);
    bus_rd(CHAN_OFFSET, 1'b0, 8'h00);
    bus_wr(CHAN_OFFSET, 8'ha5, 1'b0);
    bus_rd(CHAN_OFFSET, 1'b0, 8'ha5);
    bus_wr(CHAN_OFFSET, 8'h5a, 1'b0);
    bus_rd(CHAN_OFFSET, 1'b0, 8'hda);
    u_dbg.scan(1'b1, IR_W, 9'(INS_CHAN_READ), dr);
    dbg_read(9'h1a5);
    dbg_read(9'h05a);
    bus_rd(CHAN_OFFSET, 1'b0, 8'h5a);
    // fill the queue until it refuses; the fifth byte still lands in the register
    for (int i = 1; i <= 4; i++) bus_wr(CHAN_OFFSET, 8'(i), 1'b0);
    #1;
    check1(chan_wr_ready, 1'b0);
    bus_rd(CSR_OFFSET, 1'b0, 8'h07);
    bus_wr(CHAN_OFFSET, 8'h05, 1'b0);
    bus_rd(CHAN_OFFSET, 1'b0, 8'h85);
    for (int i = 1; i <= 4; i++) dbg_read({i == 1, 8'(i)});
    check1(chan_wr_ready, 1'b1);
    dbg_read(9'h005);
    // bypass: captured zero comes out first, then the tdi bit shifted in
    u_dbg.scan(1'b1, IR_W, 9'(INS_BYPASS), dr);
    u_dbg.scan(1'b0, 2, 9'h003, dr);
    check8({6'h00, dr[1:0]}, 8'h02);
    // disable bit shuts the port and with it the debugger grant
    bus_wr(CSR_OFFSET, 8'h80, 1'b0);
    repeat (2) @(posedge sys_clk);
    check1(tap_enabled, 1'b0);
    check1(tdo_oe, 1'b0);
    bus_rd(CSR_OFFSET, 1'b0, 8'h80);
    bus_rd(CHAN_OFFSET, 1'b1, 8'h3c);
    bus_wr(CSR_OFFSET, 8'h00, 1'b0);
    repeat (2) @(posedge sys_clk);
    check1(tap_enabled, 1'b1);
    dbg_grant();
    @(posedge sys_clk);
    fuses.debug_enable_fuse <= 1'b0;
    repeat (5) @(posedge sys_clk);
    bus_wr(CHAN_OFFSET, 8'h11, 1'b1);
    bus_rd(CSR_OFFSET, 1'b0, 8'h01);
    fuses.debug_enable_fuse <= 1'b1;
    repeat (5) @(posedge sys_clk);
    bus_rd(CHAN_OFFSET, 1'b0, 8'h05);
    fuses.test_port_enable_fuse <= 1'b0;
    repeat (5) @(posedge sys_clk);
    check1(tap_enabled, 1'b0);
    tally_and_finish();
  end
endmodule // dcc_channel_test
